// ### core/msc_cmd_parser.sv
module msc_cmd_parser (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  output msc_pkg::msc_cmd_type cmd_code,
  output logic cmd_valid,
  output logic signed [15:0] cmd_arg,
  output logic cmd_bad,
  output logic exec_pulse
);

  logic active_r;
  msc_pkg::msc_cmd_type code_r;
  logic neg_r;
  logic dot_r;
  logic any_digit_r;
  logic bad_r;
  logic [6:0] int_r;
  logic [6:0] frac_r;
  logic [1:0] nfrac_r;

  wire is_digit = (char_data >= 8'h30) && (char_data <= 8'h39);
  wire [6:0] digit = {3'h0, char_data[3:0]};
  wire is_letter = (char_data >= 8'h41) && (char_data <= 8'h5A);
  wire [13:0] int_next_w = {7'h00, int_r} * 14'd10 + {7'h00, digit};
  wire int_ovf = int_next_w > {7'h00, msc_pkg::INT_MAX};
  wire [6:0] frac_scaled = (nfrac_r == 2'h1) ? 7'(frac_r * 7'd10) : frac_r;
  wire [15:0] mag_w = 16'(int_r * 16'd100) + {9'h000, frac_scaled};
  wire signed [15:0] value_w = neg_r ? -$signed(mag_w) : $signed(mag_w);

  msc_pkg::msc_cmd_type letter_code;
  always_comb begin
    unique case (char_data)
      msc_pkg::CH_SUPPRESS: letter_code = msc_pkg::MSC_CMD_SUPPRESS;
      msc_pkg::CH_FILTER: letter_code = msc_pkg::MSC_CMD_FILTER;
      msc_pkg::CH_HIGH: letter_code = msc_pkg::MSC_CMD_HIGH;
      msc_pkg::CH_LOW: letter_code = msc_pkg::MSC_CMD_LOW;
      msc_pkg::CH_LEVEL: letter_code = msc_pkg::MSC_CMD_LEVEL;
      default: letter_code = msc_pkg::MSC_CMD_NONE;
    endcase
  end

  // A letter or the execute character closes the open command; digits build its argument.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= 1'b0;
      code_r <= msc_pkg::MSC_CMD_NONE;
      neg_r <= 1'b0;
      dot_r <= 1'b0;
      any_digit_r <= 1'b0;
      bad_r <= 1'b0;
      int_r <= 7'h00;
      frac_r <= 7'h00;
      nfrac_r <= 2'h0;
      cmd_valid <= 1'b0;
      cmd_code <= msc_pkg::MSC_CMD_NONE;
      cmd_arg <= 16'sh0000;
      cmd_bad <= 1'b0;
      exec_pulse <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      exec_pulse <= 1'b0;
      if (char_valid) begin
        if (is_letter) begin
          cmd_valid <= active_r;
          cmd_code <= code_r;
          cmd_arg <= value_w;
          cmd_bad <= bad_r || (!any_digit_r && code_r != msc_pkg::MSC_CMD_NONE);
          exec_pulse <= (char_data == msc_pkg::CH_EXECUTE);
          active_r <= (char_data != msc_pkg::CH_EXECUTE);
          code_r <= letter_code;
          neg_r <= 1'b0;
          dot_r <= 1'b0;
          any_digit_r <= 1'b0;
          bad_r <= 1'b0;
          int_r <= 7'h00;
          frac_r <= 7'h00;
          nfrac_r <= 2'h0;
        end else if (is_digit) begin
          any_digit_r <= 1'b1;
          if (!active_r || (dot_r && nfrac_r == msc_pkg::FRAC_DIGITS) || (!dot_r && int_ovf)) begin
            bad_r <= 1'b1;
            active_r <= 1'b1;
          end else if (dot_r) begin
            frac_r <= 7'(frac_r * 7'd10 + digit);
            nfrac_r <= nfrac_r + 2'h1;
          end else begin
            int_r <= int_next_w[6:0];
          end
        end else if (char_data == msc_pkg::CH_MINUS && active_r && !any_digit_r && !neg_r && !dot_r) begin
          neg_r <= 1'b1;
        end else if (char_data == msc_pkg::CH_DOT && active_r && !dot_r) begin
          dot_r <= 1'b1;
        end else if (char_data != msc_pkg::CH_SPACE) begin
          bad_r <= 1'b1;
          active_r <= 1'b1;
        end
      end
    end
  end

endmodule : msc_cmd_parser

// ### core/msc_pkg.sv
package msc_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FILTER = 8'h0C;
  localparam logic [7:0] ADDR_HIGH = 8'h10;
  localparam logic [7:0] ADDR_LOW = 8'h14;
  localparam logic [7:0] ADDR_LEVEL = 8'h18;
  localparam logic [7:0] ADDR_BASELINE = 8'h1C;

  // Control register bit positions.
  localparam int CTRL_DEV_CLEAR = 0;
  localparam int CTRL_ERR_CLEAR = 1;

  // Status register bit positions.
  localparam int STAT_SUPPRESS = 0;
  localparam int STAT_BASE_VALID = 1;
  localparam int STAT_CMD_ERROR = 2;
  localparam int STAT_PENDING = 3;
  localparam int STAT_STAIR_STOP = 4;

  // Voltage settings in hundredths of a volt, filter and suppression limits in whole units, and their values after reset.
  localparam logic signed [15:0] VOLT_MAX = 16'sh07D0;
  localparam logic signed [15:0] VOLT_MIN = -16'sh07D0;
  localparam logic signed [15:0] HIGH_RESET = 16'sh07D0;
  localparam logic signed [15:0] LOW_RESET = -16'sh07D0;
  localparam logic signed [15:0] LEVEL_RESET = 16'sh0000;
  localparam logic [1:0] FILTER_RESET = 2'h0;
  localparam logic [1:0] FILTER_MAX = 2'h3;
  localparam logic signed [15:0] SUPPRESS_MAX = 16'sh0001;

  // Argument digit limits.
  localparam logic [6:0] INT_MAX = 7'h63;
  localparam logic [1:0] FRAC_DIGITS = 2'h2;

  // Command characters.
  localparam logic [7:0] CH_SUPPRESS = 8'h4E;
  localparam logic [7:0] CH_FILTER = 8'h50;
  localparam logic [7:0] CH_HIGH = 8'h48;
  localparam logic [7:0] CH_LOW = 8'h4C;
  localparam logic [7:0] CH_LEVEL = 8'h56;
  localparam logic [7:0] CH_EXECUTE = 8'h58;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_SPACE = 8'h20;

  // Waveform selections seen from the source logic.
  localparam logic [1:0] WAVE_OFF = 2'h0;
  localparam logic [1:0] WAVE_DC = 2'h1;

  typedef enum logic [2:0] {
    MSC_CMD_NONE,
    MSC_CMD_SUPPRESS,
    MSC_CMD_FILTER,
    MSC_CMD_HIGH,
    MSC_CMD_LOW,
    MSC_CMD_LEVEL
  } msc_cmd_type;

endpackage : msc_pkg

// ### core/msc_setup_handler.sv
// Notes on behaviour
// - N1 enables suppression, captures next reading.
// - Subtract baseline from capacitance/current, never charge-rate.
// - Overrange judged on baseline-adjusted result.
// - Indicator on at once; capture after trigger.
// - Function change cancels suppression.
// - Reset or device clear disables suppression.
// - Filter levels zero to three accepted.
// - Reset or device clear turns filter off.
// - Upper bound in span; level never above.
// - Rising staircase stops at upper bound.
// - Reset or device clear: upper bound +20V.
// - Lower bound in span; level never below.
// - Falling staircase stops at lower bound.
// - Reset or device clear: lower bound -20V.
// - Shortened numeric arguments accepted, 5 means 5.00.
// - Source level must lie within bounds.
// - Storing a level changes output only while DC is selected.
// - Staircase starts from source level.
// - Reset or device clear: source level zero.
// - Commands buffered, applied in order on execute.
module msc_setup_handler #(
  parameter int READ_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reading_valid,
  input wire logic signed [READ_W-1:0] reading_value,
  input wire logic reading_is_qt,
  input wire logic [READ_W-1:0] full_scale,
  input wire logic awaiting_trigger_message,
  input wire logic function_change,
  input wire logic [1:0] waveform_sel,
  input wire logic stair_start,
  input wire logic stair_step,
  input wire logic signed [15:0] step_size,
  output logic signed [READ_W-1:0] result_value,
  output logic result_valid,
  output logic result_overrange,
  output logic suppress_on,
  output logic [1:0] filter_level,
  output logic signed [15:0] high_bound,
  output logic signed [15:0] low_bound,
  output logic signed [15:0] source_level,
  output logic signed [15:0] output_level,
  output logic stair_stopped
);

  function automatic logic signed [15:0] clamp_level(input logic signed [15:0] v,
                                                     input logic signed [15:0] lo,
                                                     input logic signed [15:0] hi);
    clamp_level = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction : clamp_level

  function automatic logic in_span(input logic signed [15:0] v, input logic signed [15:0] lo,
                                   input logic signed [15:0] hi);
    in_span = (v >= lo) && (v <= hi);
  endfunction : in_span

  // APB decode.
  wire setup_w = psel && !penable;
  wire access_w = psel && penable && pready;
  wire wr_w = access_w && pwrite;
  wire addr_ok_w = (paddr[1:0] == 2'h0) && (paddr <= msc_pkg::ADDR_BASELINE);
  wire cmd_wr_w = wr_w && paddr == msc_pkg::ADDR_CMD;
  wire ctrl_wr_w = wr_w && paddr == msc_pkg::ADDR_CTRL;
  wire dev_clear_w = ctrl_wr_w && pwdata[msc_pkg::CTRL_DEV_CLEAR];
  wire err_clear_w = ctrl_wr_w && pwdata[msc_pkg::CTRL_ERR_CLEAR];

  // Parser outputs.
  msc_pkg::msc_cmd_type cmd_code;
  logic cmd_valid;
  logic signed [15:0] cmd_arg;
  logic cmd_bad;
  logic exec_pulse;

  msc_cmd_parser u_parser (
    .pclk(pclk),
    .presetn(presetn),
    .char_valid(cmd_wr_w),
    .char_data(pwdata[7:0]),
    .cmd_code(cmd_code),
    .cmd_valid(cmd_valid),
    .cmd_arg(cmd_arg),
    .cmd_bad(cmd_bad),
    .exec_pulse(exec_pulse)
  );

  // Pending settings held until execute.
  logic pend_sup_set_r;
  logic pend_sup_r;
  logic pend_panel_filter_menu_set_r;
  logic [1:0] pend_panel_filter_menu_r;
  logic pend_high_set_r;
  logic signed [15:0] pend_high_r;
  logic pend_low_set_r;
  logic signed [15:0] pend_low_r;
  logic pend_level_set_r;
  logic signed [15:0] pend_level_r;
  logic string_bad_r;
  logic cmd_error_r;
  logic suppress_en_r;
  logic base_valid_r;
  logic signed [READ_W-1:0] baseline_r;
  logic signed [15:0] stair_level_r;
  logic exec_d_r;

  // Argument checks on each closed command.
  wire signed [15:0] arg_whole_w = cmd_arg / 16'sd100;
  wire arg_bad_w = cmd_bad ||
    (cmd_code == msc_pkg::MSC_CMD_SUPPRESS && !in_span(arg_whole_w, 16'sh0000, msc_pkg::SUPPRESS_MAX)) ||
    (cmd_code == msc_pkg::MSC_CMD_FILTER && !in_span(arg_whole_w, 16'sh0000, {14'h0000, msc_pkg::FILTER_MAX})) ||
    ((cmd_code == msc_pkg::MSC_CMD_HIGH || cmd_code == msc_pkg::MSC_CMD_LOW ||
      cmd_code == msc_pkg::MSC_CMD_LEVEL) && !in_span(cmd_arg, msc_pkg::VOLT_MIN, msc_pkg::VOLT_MAX));
  wire whole_w = (cmd_arg % 16'sd100) == 16'sh0000;
  wire int_bad_w = (cmd_code == msc_pkg::MSC_CMD_SUPPRESS || cmd_code == msc_pkg::MSC_CMD_FILTER) && !whole_w;
  wire take_w = cmd_valid && !arg_bad_w && !int_bad_w;
  wire [1:0] arg_small_w = arg_whole_w[1:0];

  // Bounds and level after the buffered string would be applied.
  wire signed [15:0] new_high_w = pend_high_set_r ? pend_high_r : high_bound;
  wire signed [15:0] new_low_w = pend_low_set_r ? pend_low_r : low_bound;
  wire signed [15:0] new_level_w = pend_level_set_r ? pend_level_r : source_level;
  wire [1:0] new_filter_w = pend_panel_filter_menu_set_r ? pend_panel_filter_menu_r : filter_level;
  wire level_ok_w = in_span(new_level_w, new_low_w, new_high_w) && (new_low_w <= new_high_w);
  wire apply_w = exec_d_r && !string_bad_r && level_ok_w;
  wire exec_fail_w = exec_d_r && !apply_w;

  // The execute pulse waits one cycle so that the command it closes is buffered first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_d_r <= 1'b0;
    end else begin
      exec_d_r <= exec_pulse;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_sup_set_r <= 1'b0;
      pend_sup_r <= 1'b0;
      pend_panel_filter_menu_set_r <= 1'b0;
      pend_panel_filter_menu_r <= msc_pkg::FILTER_RESET;
      pend_high_set_r <= 1'b0;
      pend_high_r <= msc_pkg::HIGH_RESET;
      pend_low_set_r <= 1'b0;
      pend_low_r <= msc_pkg::LOW_RESET;
      pend_level_set_r <= 1'b0;
      pend_level_r <= msc_pkg::LEVEL_RESET;
      string_bad_r <= 1'b0;
    end else if (exec_d_r || dev_clear_w) begin
      pend_sup_set_r <= 1'b0;
      pend_panel_filter_menu_set_r <= 1'b0;
      pend_high_set_r <= 1'b0;
      pend_low_set_r <= 1'b0;
      pend_level_set_r <= 1'b0;
      string_bad_r <= 1'b0;
    end else if (cmd_valid) begin
      if (!take_w) begin
        string_bad_r <= 1'b1;
      end else begin
        unique case (cmd_code)
          msc_pkg::MSC_CMD_SUPPRESS: begin
            pend_sup_set_r <= 1'b1;
            pend_sup_r <= arg_small_w[0];
          end
          msc_pkg::MSC_CMD_FILTER: begin
            pend_panel_filter_menu_set_r <= 1'b1;
            pend_panel_filter_menu_r <= arg_small_w;
          end
          msc_pkg::MSC_CMD_HIGH: begin
            pend_high_set_r <= 1'b1;
            pend_high_r <= cmd_arg;
          end
          msc_pkg::MSC_CMD_LOW: begin
            pend_low_set_r <= 1'b1;
            pend_low_r <= cmd_arg;
          end
          msc_pkg::MSC_CMD_LEVEL: begin
            pend_level_set_r <= 1'b1;
            pend_level_r <= cmd_arg;
          end
          msc_pkg::MSC_CMD_NONE: begin
          end
        endcase
      end
    end
  end

  // Applied settings.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_level <= msc_pkg::FILTER_RESET;
      high_bound <= msc_pkg::HIGH_RESET;
      low_bound <= msc_pkg::LOW_RESET;
      source_level <= msc_pkg::LEVEL_RESET;
    end else if (dev_clear_w) begin
      filter_level <= msc_pkg::FILTER_RESET;
      high_bound <= msc_pkg::HIGH_RESET;
      low_bound <= msc_pkg::LOW_RESET;
      source_level <= msc_pkg::LEVEL_RESET;
    end else if (apply_w) begin
      filter_level <= new_filter_w;
      high_bound <= new_high_w;
      low_bound <= new_low_w;
      source_level <= new_level_w;
    end
  end

  // Sticky command error; a new failure wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_error_r <= 1'b0;
    end else if (exec_fail_w) begin
      cmd_error_r <= 1'b1;
    end else if (err_clear_w) begin
      cmd_error_r <= 1'b0;
    end
  end

  // Suppression state and baseline capture.
  wire sup_apply_w = apply_w && pend_sup_set_r;
  wire capture_w = suppress_en_r && !base_valid_r && reading_valid && !awaiting_trigger_message &&
                   !reading_is_qt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suppress_en_r <= 1'b0;
      suppress_on <= 1'b0;
      base_valid_r <= 1'b0;
      baseline_r <= '0;
    end else if (dev_clear_w || function_change) begin
      suppress_en_r <= 1'b0;
      suppress_on <= 1'b0;
      base_valid_r <= 1'b0;
    end else if (sup_apply_w) begin
      suppress_en_r <= pend_sup_r;
      suppress_on <= pend_sup_r;
      base_valid_r <= 1'b0;
    end else if (capture_w) begin
      baseline_r <= reading_value;
      base_valid_r <= 1'b1;
    end
  end

  // Reported result with baseline removed and overrange judged on the difference.
  wire adjust_w = suppress_en_r && base_valid_r && !reading_is_qt;
  wire signed [READ_W:0] diff_w = adjust_w ? (READ_W+1)'(reading_value - baseline_r)
                                           : (READ_W+1)'(reading_value);
  wire [READ_W:0] mag_w = diff_w[READ_W] ? (READ_W+1)'(-diff_w) : diff_w;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_value <= '0;
      result_valid <= 1'b0;
      result_overrange <= 1'b0;
    end else begin
      result_valid <= reading_valid && !capture_w;
      if (reading_valid) begin
        result_value <= diff_w[READ_W-1:0];
        result_overrange <= mag_w > {1'b0, full_scale};
      end
    end
  end

  // Staircase level, started from the source level and held inside the bounds.
  wire signed [16:0] stair_next_w = 17'(stair_level_r) + 17'(step_size);
  wire stair_hit_hi_w = step_size > 16'sh0000 && stair_next_w >= 17'(high_bound);
  wire stair_hit_lo_w = step_size < 16'sh0000 && stair_next_w <= 17'(low_bound);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stair_level_r <= msc_pkg::LEVEL_RESET;
      stair_stopped <= 1'b0;
    end else if (stair_start) begin
      stair_level_r <= source_level;
      stair_stopped <= 1'b0;
    end else if (stair_step && !stair_stopped) begin
      if (stair_hit_hi_w) begin
        stair_level_r <= high_bound;
        stair_stopped <= 1'b1;
      end else if (stair_hit_lo_w) begin
        stair_level_r <= low_bound;
        stair_stopped <= 1'b1;
      end else begin
        stair_level_r <= stair_next_w[15:0];
      end
    end
  end

  // Output connector follows the waveform selection: zero, the source level or the staircase level, clamped to the bounds.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_level <= msc_pkg::LEVEL_RESET;
    end else if (waveform_sel == msc_pkg::WAVE_OFF) begin
      output_level <= msc_pkg::LEVEL_RESET;
    end else if (waveform_sel == msc_pkg::WAVE_DC) begin
      output_level <= clamp_level(source_level, low_bound, high_bound);
    end else begin
      output_level <= clamp_level(stair_level_r, low_bound, high_bound);
    end
  end

  // APB read mux and answer.
  wire pending_w = pend_sup_set_r || pend_panel_filter_menu_set_r || pend_high_set_r || pend_low_set_r || pend_level_set_r;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      msc_pkg::ADDR_STATUS: begin
        rd_mux[msc_pkg::STAT_SUPPRESS] = suppress_en_r;
        rd_mux[msc_pkg::STAT_BASE_VALID] = base_valid_r;
        rd_mux[msc_pkg::STAT_CMD_ERROR] = cmd_error_r;
        rd_mux[msc_pkg::STAT_PENDING] = pending_w;
        rd_mux[msc_pkg::STAT_STAIR_STOP] = stair_stopped;
      end
      msc_pkg::ADDR_FILTER: rd_mux = {30'h0000_0000, filter_level};
      msc_pkg::ADDR_HIGH: rd_mux = 32'(high_bound);
      msc_pkg::ADDR_LOW: rd_mux = 32'(low_bound);
      msc_pkg::ADDR_LEVEL: rd_mux = 32'(source_level);
      msc_pkg::ADDR_BASELINE: rd_mux = 32'(baseline_r);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_w;
      pslverr <= setup_w && !addr_ok_w;
      if (setup_w) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule : msc_setup_handler

// ### verif/msc_host_model.sv
module msc_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
endmodule : msc_host_model

// ### verif/msc_setup_handler_sva.sv
module msc_setup_chk #(
  parameter int READ_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic reading_valid,
  input wire logic reading_is_qt,
  input wire logic signed [READ_W-1:0] reading_value,
  input wire logic [READ_W-1:0] full_scale,
  input wire logic function_change,
  input wire logic [1:0] waveform_sel,
  input wire logic signed [READ_W-1:0] result_value,
  input wire logic result_valid,
  input wire logic result_overrange,
  input wire logic suppress_on,
  input wire logic [1:0] filter_level,
  input wire logic signed [15:0] high_bound,
  input wire logic signed [15:0] low_bound,
  input wire logic signed [15:0] source_level,
  input wire logic signed [15:0] output_level,
  input wire logic stair_stopped
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic [READ_W-1:0] mag;
  assign mag = result_value[READ_W-1] ? -result_value : result_value;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_off2;
    waveform_sel == msc_pkg::WAVE_OFF ##1 waveform_sel == msc_pkg::WAVE_OFF;
  endsequence
  property p_ready;
    s_setup |=> pready ##1 !pready;
  endproperty
  property p_defaults;
    $rose(presetn) |-> high_bound == msc_pkg::HIGH_RESET && low_bound == msc_pkg::LOW_RESET
      && source_level == msc_pkg::LEVEL_RESET && filter_level == msc_pkg::FILTER_RESET && !suppress_on;
  endproperty
  property p_span;
    high_bound <= msc_pkg::VOLT_MAX && low_bound >= msc_pkg::VOLT_MIN;
  endproperty
  property p_level;
    source_level <= high_bound && source_level >= low_bound;
  endproperty
  property p_cancel;
    function_change |=> !suppress_on;
  endproperty
  property p_qt;
    reading_valid && reading_is_qt |=> result_valid && result_value == $past(reading_value);
  endproperty
  property p_over;
    result_valid && !$past(reading_is_qt) |-> result_overrange == (mag > $past(full_scale));
  endproperty
  property p_off;
    s_off2 |-> output_level == 16'sh0000;
  endproperty
  property p_stop;
    waveform_sel == 2'h3 && $rose(stair_stopped) |=> output_level == high_bound || output_level == low_bound;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
  a_defaults: assert property (p_defaults) else $error("bad values after reset");
  a_span: assert property (p_span) else $error("bound out of span");
  a_level: assert property (p_level) else $error("level outside bounds");
  a_cancel: assert property (p_cancel) else $error("suppression kept after function change");
  a_qt: assert property (p_qt) else $error("charge rate result adjusted");
  a_over: assert property (p_over) else $error("overrange flag wrong");
  a_off: assert property (p_off) else $error("output not zero while off");
  a_stop: assert property (p_stop) else $error("staircase not held at bound");
endmodule : msc_setup_chk

bind msc_setup_handler msc_setup_chk #(.READ_W(READ_W)) msc_setup_chk_i (.*);

// ### verif/test_msc_setup_handler.sv
module test_msc_setup_handler;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic reading_valid, reading_is_qt, awaiting_trigger_message, function_change, stair_start, stair_step;
  logic result_valid, result_overrange, suppress_on, stair_stopped;
  logic signed [23:0] reading_value, result_value;
  logic [23:0] full_scale;
  logic [1:0] waveform_sel, filter_level;
  logic signed [15:0] step_size, high_bound, low_bound, source_level, output_level;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  msc_setup_handler #(.READ_W(24)) msc_setup_handler_i (.*);
  msc_host_model msc_host_model_i (.*);
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    msc_host_model_i.xfer(1'h1, a, d, q, e);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    msc_host_model_i.xfer(1'h0, a, 32'h0000_0000, q, e);
    chk(nm, q, x);
  endtask : rd
  task automatic cmd(input string s);
    for (int i = 0; i < s.len(); i++) wr(msc_pkg::ADDR_CMD, {24'h00_0000, s[i]});
    repeat (4) @(posedge pclk);
  endtask : cmd
  task automatic rdg(input logic signed [23:0] v, input logic qt);
    @(posedge pclk);
    reading_valid <= 1'h1;
    reading_value <= v;
    reading_is_qt <= qt;
    @(posedge pclk);
    reading_valid <= 1'h0;
    #1;
  endtask : rdg
  task automatic stair(input logic go);
    @(posedge pclk);
    stair_start <= go;
    stair_step <= !go;
    @(posedge pclk);
    stair_start <= 1'h0;
    stair_step <= 1'h0;
    @(posedge pclk);
    #1;
  endtask : stair
  initial begin
    string s;
    reading_valid = 1'h0;
    reading_value = 24'h00_0000;
    reading_is_qt = 1'h0;
    full_scale = 24'h00_03E8;
    awaiting_trigger_message = 1'h0;
    function_change = 1'h0;
    waveform_sel = msc_pkg::WAVE_OFF;
    stair_start = 1'h0;
    stair_step = 1'h0;
    step_size = 16'sh001E;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd("high", msc_pkg::ADDR_HIGH, 32'h0000_07D0);
    rd("low", msc_pkg::ADDR_LOW, 32'hFFFF_F830);
    rd("level", msc_pkg::ADDR_LEVEL, 32'h0000_0000);
    rd("filter", msc_pkg::ADDR_FILTER, 32'h0000_0000);
    rd("status", msc_pkg::ADDR_STATUS, 32'h0000_0000);
    rd("unmapped", 8'h20, 32'h0000_0000);
    chk("slverr", {31'h0000_0000, e}, 32'h0000_0001);
    cmd("H5P0");
    rd("held", msc_pkg::ADDR_HIGH, 32'h0000_07D0);
    rd("pending", msc_pkg::ADDR_STATUS, 32'h0000_0008);
    cmd("X");
    rd("high5", msc_pkg::ADDR_HIGH, 32'h0000_01F4);
    cmd("L-10X");
    rd("low10", msc_pkg::ADDR_LOW, 32'hFFFF_FC18);
    cmd("V15X");
    rd("vabove", msc_pkg::ADDR_LEVEL, 32'h0000_0000);
    rd("error", msc_pkg::ADDR_STATUS, 32'h0000_0004);
    wr(msc_pkg::ADDR_CTRL, 32'h0000_0002);
    cmd("H25X");
    rd("hspan", msc_pkg::ADDR_HIGH, 32'h0000_01F4);
    cmd("V4.5X");
    rd("level45", msc_pkg::ADDR_LEVEL, 32'h0000_01C2);
    waveform_sel <= msc_pkg::WAVE_DC;
    chk("out_off", 32'(output_level), 32'h0000_0000);
    repeat (2) @(posedge pclk);
    #1;
    chk("out_dc", 32'(output_level), 32'h0000_01C2);
    s = "P0X";
    for (int i = 0; i < 4; i++) begin
      s[1] = 8'(8'h30 + i);
      cmd(s);
      chk("panel_filter_menu", {30'h0000_0000, filter_level}, 32'(i));
    end
    cmd("P4X");
    chk("filt4", {30'h0000_0000, filter_level}, 32'h0000_0003);
    waveform_sel <= 2'h3;
    stair(1'h1);
    chk("stair0", 32'(output_level), 32'h0000_01C2);
    stair(1'h0);
    stair(1'h0);
    chk("stairhi", 32'(output_level), 32'h0000_01F4);
    chk("stopped", {31'h0000_0000, stair_stopped}, 32'h0000_0001);
    step_size <= 16'shFC18;
    stair(1'h1);
    stair(1'h0);
    stair(1'h0);
    chk("stairlo", 32'(output_level), 32'hFFFF_FC18);
    @(posedge pclk);
    awaiting_trigger_message <= 1'h1;
    cmd("N1X");
    #1;
    chk("supp_on", {31'h0000_0000, suppress_on}, 32'h0000_0001);
    rdg(24'sh00_0064, 1'h0);
    @(posedge pclk);
    awaiting_trigger_message <= 1'h0;
    rdg(24'sh00_012C, 1'h0);
    rd("baseline", msc_pkg::ADDR_BASELINE, 32'h0000_012C);
    rdg(24'sh00_015E, 1'h0);
    chk("diff", 32'(result_value), 32'h0000_0032);
    rdg(24'sh00_015E, 1'h1);
    chk("qt", 32'(result_value), 32'h0000_015E);
    rdg(-24'sh00_0320, 1'h0);
    chk("over", {31'h0000_0000, result_overrange}, 32'h0000_0001);
    @(posedge pclk);
    function_change <= 1'h1;
    @(posedge pclk);
    function_change <= 1'h0;
    @(posedge pclk);
    #1;
    chk("cancel", {31'h0000_0000, suppress_on}, 32'h0000_0000);
    cmd("P2N1X");
    wr(msc_pkg::ADDR_CTRL, 32'h0000_0001);
    @(posedge pclk);
    #1;
    chk("clr_supp", {31'h0000_0000, suppress_on}, 32'h0000_0000);
    chk("clr_panel_filter_menu", {30'h0000_0000, filter_level}, 32'h0000_0000);
    chk("clr_high", 32'(high_bound), 32'h0000_07D0);
    chk("clr_low", 32'(low_bound), 32'hFFFF_F830);
    chk("clr_level", 32'(source_level), 32'h0000_0000);
    give_verdict();
  end
endmodule : test_msc_setup_handler
